// ===== design/adcirq_regs.svh
// Offsets, field positions and reset values of the status and mux bank.
// Assumes inclusion by adcirq_bank, bare name.
`ifndef ADCIRQ_REGS_SVH
`define ADCIRQ_REGS_SVH

// ***************************************************************
// Register offsets
// ***************************************************************
`define ADCIRQ_OFF_RESULT 4'h0
`define ADCIRQ_OFF_IRQ 4'h5
`define ADCIRQ_OFF_MUX 4'h6
`define ADCIRQ_OFF_EVT_STATUS 4'h8
`define ADCIRQ_OFF_EVT_MASK 4'h9

// ***************************************************************
// Field positions of the interrupt/status register
// ***************************************************************
`define ADCIRQ_BIT_DRDY_N 6
`define ADCIRQ_BIT_CRC_OK 5
`define ADCIRQ_BIT_POR_N 4
`define ADCIRQ_BIT_PIN_MODULATOR_BITSTREAM 3
`define ADCIRQ_BIT_PIN_PUSH 2
`define ADCIRQ_BIT_FASTCMD 1
`define ADCIRQ_BIT_STP 0

// ***************************************************************
// Reset values
// ***************************************************************
`define ADCIRQ_RST_CTRL 4'h3
`define ADCIRQ_RST_MUX 8'h01
`define ADCIRQ_RST_MASK 5'h00

// ***************************************************************
// Event status bit positions
// ***************************************************************
`define ADCIRQ_EVT_DRDY 0
`define ADCIRQ_EVT_CRC 1
`define ADCIRQ_EVT_POR 2
`define ADCIRQ_EVT_STP 3
`define ADCIRQ_EVT_FREJ 4

`endif

// ===== design/adcirq_pkg.sv
// Types shared by the status and mux bank.
// Needs nothing from the constants header.
package adcirq_pkg;
  typedef enum logic [1:0] {
    ADCIRQ_PIN_IDLE,
    ADCIRQ_PIN_IRQ,
    ADCIRQ_PIN_MODULATOR_BITSTREAM
  } adcirq_pin_type;
endpackage : adcirq_pkg

// ===== design/adcirq_pin.sv
// Drives the shared interrupt/bitstream pin as two signals.
// Assumes the caller decides source and level; the pad resolves the wire.
`timescale 1ns/1ns
`default_nettype none
module adcirq_pin
  import adcirq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire adcirq_pin_type i_src,
  input wire logic i_modulator_bitstream,
  input wire logic i_push_pull,
  output logic o_pin_o,
  output logic o_pin_oe
);
  logic level;

  // Interrupt is active low; the bitstream is sent as is.
  always_comb begin
    case (i_src)
      ADCIRQ_PIN_IRQ: level = 1'b0;
      ADCIRQ_PIN_MODULATOR_BITSTREAM: level = i_modulator_bitstream;
      ADCIRQ_PIN_IDLE: level = 1'b1;
      default: level = 1'b1;
    endcase
  end

  // A high level is only driven in push-pull; open drain releases it.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pin_o <= 1'b1;
      o_pin_oe <= 1'b0;
    end else begin
      o_pin_o <= level;
      o_pin_oe <= !level || i_push_pull;
    end
  end
endmodule : adcirq_pin
`default_nettype wire

// ===== design/adcirq_bank.sv
// Interrupt/status register, input multiplexer register and event interrupt.
// Assumes a one-cycle register port and converter events as one-cycle pulses.
//
// The implementer's own choice: the strobed register port.
`include "adcirq_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module adcirq_bank
  import adcirq_pkg::*;
#(
  parameter int RESULT_W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_result_valid,
  input wire logic [RESULT_W-1:0] i_result,
  input wire logic i_crc_error,
  input wire logic i_por_event,
  input wire logic i_conv_start,
  input wire logic i_modulator_bitstream,
  input wire logic i_fast_cmd,
  output logic [7:0] o_rdata,
  output logic o_fast_cmd_exec,
  output logic [3:0] o_positive_input_select,
  output logic [3:0] o_negative_input_select,
  output logic o_pin_o,
  output logic o_pin_oe,
  output logic o_irq
);
  // The bitstream shift and the low result byte need at least 8 bits.
  if (RESULT_W < 8 || RESULT_W > 32) begin : g_bad_result_w
    $error("RESULT_W must be 8 to 32");
  end

  // ***************************************************************
  // Register state
  // ***************************************************************
  logic [3:0] ctrl_r;
  logic data_ready_flag_n_r;
  logic config_check_ok_flag_r;
  logic por_flag_n_r;
  logic [7:0] mux_r;
  logic [RESULT_W-1:0] result_r;
  logic [RESULT_W-1:0] modulator_bitstream_shift_r;
  logic [4:0] evt_status_r;
  logic [4:0] evt_mask_r;
  logic [4:0] evt_set;
  logic wr_irq;
  logic rd_irq;
  logic rd_result;
  logic modulator_bitstream_mode;
  logic push_pull;
  logic fast_command_enable;
  logic conversion_start_irq_enable;
  adcirq_pin_type pin_src;

  assign wr_irq = i_wr && (i_addr == `ADCIRQ_OFF_IRQ);
  assign rd_irq = i_rd && (i_addr == `ADCIRQ_OFF_IRQ);
  assign rd_result = i_rd && (i_addr == `ADCIRQ_OFF_RESULT);
  assign modulator_bitstream_mode = ctrl_r[`ADCIRQ_BIT_PIN_MODULATOR_BITSTREAM];
  assign push_pull = ctrl_r[`ADCIRQ_BIT_PIN_PUSH];
  assign fast_command_enable = ctrl_r[`ADCIRQ_BIT_FASTCMD];
  assign conversion_start_irq_enable = ctrl_r[`ADCIRQ_BIT_STP];

  // ***************************************************************
  // Writable control field
  // ***************************************************************
  // Only bits 3:0 are stored, so bit 7 and the flags ignore writes.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_r <= `ADCIRQ_RST_CTRL;
    end else if (wr_irq) begin
      ctrl_r <= i_wdata[3:0];
    end
  end

  // ***************************************************************
  // Read-only flags
  // ***************************************************************
  // A new result wins over a read in the same cycle so it is never missed.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      data_ready_flag_n_r <= 1'b1;
    end else if (i_result_valid) begin
      data_ready_flag_n_r <= 1'b0;
    end else if (rd_result) begin
      data_ready_flag_n_r <= 1'b1;
    end
  end

  // The CRC flag stays low once an error is seen, until reset.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      config_check_ok_flag_r <= 1'b1;
    end else if (i_crc_error) begin
      config_check_ok_flag_r <= 1'b0;
    end
  end

  // Cleared by reading the register; a fresh event beats the read.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      por_flag_n_r <= 1'b1;
    end else if (i_por_event) begin
      por_flag_n_r <= 1'b0;
    end else if (rd_irq) begin
      por_flag_n_r <= 1'b1;
    end
  end

  // ***************************************************************
  // Multiplexer register
  // ***************************************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mux_r <= `ADCIRQ_RST_MUX;
    end else if (i_wr && (i_addr == `ADCIRQ_OFF_MUX)) begin
      mux_r <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_positive_input_select <= 4'h0;
      o_negative_input_select <= 4'h1;
    end else begin
      o_positive_input_select <= mux_r[7:4];
      o_negative_input_select <= mux_r[3:0];
    end
  end

  // ***************************************************************
  // Result register and bitstream capture
  // ***************************************************************
  // In bitstream mode the result register shows the last modulator codes.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      modulator_bitstream_shift_r <= '0;
    end else begin
      modulator_bitstream_shift_r <= {modulator_bitstream_shift_r[RESULT_W-2:0], i_modulator_bitstream};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      result_r <= '0;
    end else if (modulator_bitstream_mode) begin
      result_r <= modulator_bitstream_shift_r;
    end else if (i_result_valid) begin
      result_r <= i_result;
    end
  end

  // ***************************************************************
  // Fast command gate
  // ***************************************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_fast_cmd_exec <= 1'b0;
    end else begin
      o_fast_cmd_exec <= i_fast_cmd && fast_command_enable;
    end
  end

  // ***************************************************************
  // Read data
  // ***************************************************************
  // Unmapped offsets read zero; the low result byte stands at offset 0.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `ADCIRQ_OFF_RESULT: o_rdata <= result_r[7:0];
        `ADCIRQ_OFF_IRQ: o_rdata <= {1'b0, data_ready_flag_n_r, config_check_ok_flag_r,
                                     por_flag_n_r, ctrl_r};
        `ADCIRQ_OFF_MUX: o_rdata <= mux_r;
        `ADCIRQ_OFF_EVT_STATUS: o_rdata <= {3'h0, evt_status_r};
        `ADCIRQ_OFF_EVT_MASK: o_rdata <= {3'h0, evt_mask_r};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ***************************************************************
  // Sticky events and mask
  // ***************************************************************
  always_comb begin
    evt_set = 5'h00;
    evt_set[`ADCIRQ_EVT_DRDY] = i_result_valid;
    evt_set[`ADCIRQ_EVT_CRC] = i_crc_error;
    evt_set[`ADCIRQ_EVT_POR] = i_por_event;
    evt_set[`ADCIRQ_EVT_STP] = i_conv_start && conversion_start_irq_enable;
    evt_set[`ADCIRQ_EVT_FREJ] = i_fast_cmd && !fast_command_enable;
  end

  // Write one to clear; a set in the same cycle wins.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      evt_status_r <= 5'h00;
    end else if (i_wr && (i_addr == `ADCIRQ_OFF_EVT_STATUS)) begin
      evt_status_r <= (evt_status_r & ~i_wdata[4:0]) | evt_set;
    end else begin
      evt_status_r <= evt_status_r | evt_set;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      evt_mask_r <= `ADCIRQ_RST_MASK;
    end else if (i_wr && (i_addr == `ADCIRQ_OFF_EVT_MASK)) begin
      evt_mask_r <= i_wdata[4:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(evt_status_r & evt_mask_r);
    end
  end

  // ***************************************************************
  // Pin source selection
  // ***************************************************************
  // The pin reports interrupts while a flag is pending; in bitstream mode
  // only power-on and CRC faults may take it over.
  always_comb begin
    if (!por_flag_n_r || !config_check_ok_flag_r) begin
      pin_src = ADCIRQ_PIN_IRQ;
    end else if (modulator_bitstream_mode) begin
      pin_src = ADCIRQ_PIN_MODULATOR_BITSTREAM;
    end else if (!data_ready_flag_n_r || evt_status_r[`ADCIRQ_EVT_STP]) begin
      pin_src = ADCIRQ_PIN_IRQ;
    end else begin
      pin_src = ADCIRQ_PIN_IDLE;
    end
  end

  adcirq_pin u_pin (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_src(pin_src),
    .i_modulator_bitstream(i_modulator_bitstream),
    .i_push_pull(push_pull),
    .o_pin_o(o_pin_o),
    .o_pin_oe(o_pin_oe)
  );
endmodule : adcirq_bank
`default_nettype wire

// ===== tb/adcirq_bank_assertions.sv
// Port checker for the status and mux bank.
// Assumes a bind onto adcirq_bank and one clock domain.
`timescale 1ns/1ns
`default_nettype none
module adcirq_bank_assertions (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_fast_cmd,
  input wire logic [7:0] o_rdata,
  input wire logic o_fast_cmd_exec,
  input wire logic [3:0] o_positive_input_select,
  input wire logic [3:0] o_negative_input_select,
  input wire logic o_pin_o,
  input wire logic o_pin_oe,
  input wire logic o_irq
);
  // ****************
  // Properties
  // ****************
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_rd_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata idle");
  property p_top0; $past(i_rd) && $past(i_addr) == 4'h5 |-> !o_rdata[7]; endproperty
  a_top0: assert property (p_top0) else $error("bit 7 set");
  property p_unmap; $past(i_rd) && $past(i_addr) == 4'h7 |-> o_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_fast; o_fast_cmd_exec |-> $past(i_fast_cmd); endproperty
  a_fast: assert property (p_fast) else $error("fast exec");
  property p_mux_rst; $past(i_rst) |-> {o_positive_input_select, o_negative_input_select} == 8'h01;
  endproperty
  a_mux_rst: assert property (p_mux_rst) else $error("mux reset");
  property p_out_rst; $past(i_rst) |-> !o_irq && !o_pin_oe && !o_fast_cmd_exec; endproperty
  a_out_rst: assert property (p_out_rst) else $error("outputs reset");
  // A second mux write right behind the first reaches the outputs only after the check.
  property p_mux_wr; i_wr && i_addr == 4'h6 ##1 !(i_wr && i_addr == 4'h6)
    |=> {o_positive_input_select, o_negative_input_select} == $past(i_wdata, 2); endproperty
  a_mux_wr: assert property (p_mux_wr) else $error("mux write");
  property p_low_drv; !o_pin_o |-> o_pin_oe; endproperty
  a_low_drv: assert property (p_low_drv) else $error("low not driven");
  c_rd5: cover property (i_rd && i_addr == 4'h5);
  c_exec: cover property (o_fast_cmd_exec);
  c_irq: cover property ($rose(o_irq));
endmodule : adcirq_bank_assertions
bind adcirq_bank adcirq_bank_assertions u_chk (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
  .i_fast_cmd, .o_rdata, .o_fast_cmd_exec, .o_positive_input_select, .o_negative_input_select,
  .o_pin_o, .o_pin_oe, .o_irq);
`default_nettype wire

// ===== tb/adcirq_host.sv
// Host model on the register port of the bank.
// Assumes its tasks are entered in the time step of a rising edge.
`timescale 1ns/1ns
`default_nettype none
module adcirq_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [3:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  // ****************
  // Bus cycles
  // ****************
  initial begin
    o_addr = 4'h0;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // One idle edge after each strobe, so a strobe is never rewritten in one step.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    @(posedge i_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    #1;
    q = i_rdata;
    @(posedge i_clk);
  endtask : rd
endmodule : adcirq_host
`default_nettype wire

// ===== tb/test_adc_irq_status_and_mux_regs.sv
// Self-checking bench for the status and mux bank.
// Assumes the bank, its checker and the host model are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module test_adc_irq_status_and_mux_regs;
  // ****************
  // Bench
  // ****************
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [4:0] ev = 5'h00;
  logic modulator_bitstream = 1'b0;
  logic [3:0] addr, pos, neg;
  logic [7:0] wdata, rdata;
  logic wr, rd, exec, pin_o, pin_oe, irq;
  int errors = 0;
  int compares = 0;
  logic [19:0] rows [6] = '{20'h5f373, 20'h50070, 20'h6a5a5, 20'h65a5a, 20'h7ff00, 20'h90101};
  wire logic [15:0] obs = {pos, neg, 4'h0, irq, pin_o, pin_oe, exec};
  always #5 i_clk = ~i_clk;
  adcirq_bank DUT (.i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .i_result_valid(ev[0]), .i_result(16'h1234), .i_crc_error(ev[1]),
    .i_por_event(ev[2]), .i_conv_start(ev[3]), .i_modulator_bitstream(modulator_bitstream), .i_fast_cmd(ev[4]),
    .o_rdata(rdata), .o_fast_cmd_exec(exec), .o_positive_input_select(pos),
    .o_negative_input_select(neg), .o_pin_o(pin_o), .o_pin_oe(pin_oe), .o_irq(irq));
  adcirq_host host (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd));
  task chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] q;
    host.rd(a, q);
    chk({8'h00, q & m}, {8'h00, e});
  endtask : rc
  task co(input logic [15:0] m, input logic [15:0] e);
    #1;
    chk(obs & m, e);
    @(posedge i_clk);
  endtask : co
  task pulse(input int b);
    ev[b] <= 1'b1;
    @(posedge i_clk);
    ev <= 5'h00;
  endtask : pulse
  task fresh();
    i_rst <= 1'b1;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    rc(4'h5, 8'hff, 8'h73);
    rc(4'h6, 8'hff, 8'h01);
    co(16'hff00, 16'h0100);
  endtask : fresh
  task results();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  initial begin
    repeat (3000) @(posedge i_clk);
    errors++;
    results();
  end
  initial begin
    fresh();
    foreach (rows[i]) begin
      host.wr(rows[i][19:16], rows[i][15:8]);
      rc(rows[i][19:16], 8'hff, rows[i][7:0]);
    end
    co(16'hff00, 16'h5a00);
    pulse(4);
    co(16'h0001, 16'h0000);
    host.wr(4'h5, 8'h02);
    pulse(4);
    co(16'h0001, 16'h0001);
    host.wr(4'h8, 8'hff);
    host.wr(4'h9, 8'h01);
    pulse(0);
    @(posedge i_clk);
    co(16'h0008, 16'h0008);
    rc(4'h5, 8'hff, 8'h32);
    rc(4'h0, 8'hff, 8'h34);
    rc(4'h5, 8'hff, 8'h72);
    host.wr(4'h8, 8'h01);
    co(16'h0008, 16'h0000);
    host.wr(4'h9, 8'h08);
    pulse(3);
    rc(4'h8, 8'hff, 8'h00);
    host.wr(4'h5, 8'h03);
    pulse(3);
    rc(4'h8, 8'hff, 8'h08);
    co(16'h000e, 16'h000a);
    host.wr(4'h8, 8'hff);
    co(16'h000e, 16'h0004);
    host.wr(4'h5, 8'h07);
    co(16'h0006, 16'h0006);
    host.wr(4'h5, 8'h0f);
    modulator_bitstream <= 1'b1;
    repeat (20) @(posedge i_clk);
    co(16'h0006, 16'h0006);
    rc(4'h0, 8'hff, 8'hff);
    modulator_bitstream <= 1'b0;
    repeat (20) @(posedge i_clk);
    co(16'h0006, 16'h0002);
    rc(4'h0, 8'hff, 8'h00);
    host.wr(4'h5, 8'h0b);
    modulator_bitstream <= 1'b1;
    repeat (20) @(posedge i_clk);
    co(16'h0006, 16'h0004);
    rc(4'h0, 8'hff, 8'hff);
    pulse(2);
    @(posedge i_clk);
    co(16'h0006, 16'h0002);
    rc(4'h5, 8'h10, 8'h00);
    rc(4'h5, 8'h10, 8'h10);
    fresh();
    pulse(1);
    rc(4'h5, 8'h20, 8'h00);
    results();
  end
endmodule : test_adc_irq_status_and_mux_regs
`default_nettype wire
